// ---- test/oc_stage_model.sv ----
// Purpose: stage-side model driving starts, trips and recorded fault currents
// Assumes: bench sets wanted levels off the edge; outputs change on the rising edge
// Notes:   a current line not strobing shows the inverse of its last value
`timescale 1ns/10ps
`include "ocstat_map.svh"
module oc_stage_model (
  input  wire logic                                     core_clk,      // system clock
  input  wire logic                                     arst_n,        // async reset
  input  wire logic [`OC_NUM_STAGES-1:0][2:0]           start_lvl,     // wanted starts
  input  wire logic [`OC_NUM_STAGES-1:0][2:0]           trip_lvl,      // wanted trips
  input  wire logic [`OC_NUM_STAGES-1:0]                cur_req,       // strobe on each rise
  input  wire logic [`OC_NUM_STAGES-1:0][`OC_CUR_W-1:0] cur_val,       // current to report
  output logic      [`OC_NUM_STAGES-1:0][2:0]           stage_start,   // start levels
  output logic      [`OC_NUM_STAGES-1:0][2:0]           stage_trip,    // trip levels
  output logic      [`OC_NUM_STAGES-1:0]                stage_cur_vld, // one-cycle strobe
  output logic      [`OC_NUM_STAGES-1:0][`OC_CUR_W-1:0] stage_cur      // recorded current
);
  logic [`OC_NUM_STAGES-1:0] req_q;
  // ----------------------------------------------------------------
  // stage outputs
  // ----------------------------------------------------------------
  // levels follow requests; a request rise gives one strobe only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_start   <= '0;
      stage_trip    <= '0;
      stage_cur_vld <= '0;
      stage_cur     <= '0;
      req_q         <= '0;
    end else begin
      stage_start   <= start_lvl;
      stage_trip    <= trip_lvl;
      req_q         <= cur_req;
      stage_cur_vld <= cur_req & ~req_q;
      for (int s = 0; s < `OC_NUM_STAGES; s++) begin
        stage_cur[s] <= (cur_req[s] & ~req_q[s]) ? cur_val[s] : ~stage_cur[s];
      end
    end
  end
endmodule : oc_stage_model

// ---- test/test_combined_overcurrent_status.sv ----
// Purpose: self-checking bench of the overcurrent status block
// Assumes: 10-cycle second tick, AHB-Lite single word transfers
// Notes:   event pulses are gathered into ev_acc and compared as a whole
`timescale 1ns/10ps
module test_combined_overcurrent_status import ocstat_pkg::*;;
  localparam logic [15:0] EN_EXP [8] = '{16'h0001, 16'h0008, 16'h0040, 16'h0080,
                                         16'h0100, 16'h0800, 16'h4000, 16'h8000};
  logic              core_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq;
  wire logic         hready;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [7:0][2:0]   start_lvl, trip_lvl, stage_start, stage_trip;
  logic [7:0]        cur_req, stage_cur_vld;
  logic [7:0][15:0]  cur_val, stage_cur;
  flags_t            flags;
  event_t            events;
  logic [15:0]       latest_fault_current, ev_acc;
  int                num_errors, check_count, cycles;
  assign hready = hreadyout;
  combined_overcurrent_status #(.TICK_CYCLES(10)) u_dut (.core_clk(core_clk), .arst_n(arst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .stage_start(stage_start), .stage_trip(stage_trip),
    .stage_cur_vld(stage_cur_vld), .stage_cur(stage_cur), .flags(flags), .events(events),
    .latest_fault_current(latest_fault_current), .irq(irq));
  oc_stage_model u_stages (.core_clk(core_clk), .arst_n(arst_n), .start_lvl(start_lvl), .trip_lvl(trip_lvl),
    .cur_req(cur_req), .cur_val(cur_val), .stage_start(stage_start), .stage_trip(stage_trip),
    .stage_cur_vld(stage_cur_vld), .stage_cur(stage_cur));
  // ----------------------------------------------------------------
  // clock, reset, timeout and event gathering
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0; arst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = '0; hwdata = '0;
    htrans = 2'h0; hsize = 3'h2; start_lvl = '0; trip_lvl = '0; cur_req = '0; cur_val = '0;
    ev_acc = '0; num_errors = 0; check_count = 0; cycles = 0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
  end
  always #2.5 core_clk = ~core_clk;
  always @(negedge core_clk) begin
    ev_acc = ev_acc | events;
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // one single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= wr; hsize <= 3'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask : rdc
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #3;
  endtask : step
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    @(posedge arst_n);
    step(1);
    rdc(12'h000, 32'h0, "ctrl reset");
    rdc(12'h004, 32'hFF, "stage enable reset");
    rdc(12'h008, 32'h0, "alarm delay reset");
    rdc(12'h00C, 32'h0, "fault delay reset");
    rdc(12'h040, 32'h0, "unmapped read");
    // each event enable alone, zero delays, interrupt masked
    for (int i = 0; i < 8; i++) begin
      wr(12'h000, 32'h300 | (32'h1 << i));
      ev_acc = '0; start_lvl[0][0] = 1'b1; trip_lvl[0][0] = 1'b1;
      step(3);
      start_lvl = '0; trip_lvl = '0;
      step(4);
      check(ev_acc, EN_EXP[i], "single event enable");
    end
    check(irq, 1'b0, "masked irq");
    check(hresp, 1'b0, "okay response");
    rdc(12'h018, 32'hF, "irq status");
    wr(12'h020, 32'hF); step(2); check(irq, 1'b1, "irq raised");
    wr(12'h01C, 32'hF); step(2); check(irq, 1'b0, "irq cleared");
    rdc(12'h018, 32'h0, "irq status cleared");
    // start group with repeats allowed and a two-second hold
    wr(12'h000, 32'h3FF); wr(12'h008, 32'h2);
    ev_acc = '0; start_lvl[0][0] = 1'b1; step(2);
    check(flags, 8'h09, "phase and combined start");
    check(ev_acc, 16'h0041, "start on events");
    check(irq, 1'b1, "irq on start");
    start_lvl[0][1] = 1'b1; step(2);
    check(ev_acc, 16'h0043, "repeat start event");
    rdc(12'h010, 32'h0B, "flag register");
    ev_acc = '0; start_lvl = '0; step(2);
    check(flags, 8'h0B, "start held");
    step(25); check(flags, 8'h00, "start released");
    check(ev_acc, 16'h0098, "start off events");
    // start repeats suppressed, zero hold
    wr(12'h000, 32'h2FF); wr(12'h008, 32'h0);
    ev_acc = '0; start_lvl[1][0] = 1'b1; step(2);
    start_lvl[1][1] = 1'b1; step(2);
    check(ev_acc, 16'h0041, "repeat suppressed");
    start_lvl = '0; step(1); check(flags, 8'h0B, "still on");
    step(1); check(flags, 8'h00, "zero hold drop");
    step(2); check(ev_acc, 16'h00C9, "paired off only");
    // trip group: disabled stage, suppressed repeat, three-second hold
    wr(12'h004, 32'hFE); wr(12'h000, 32'h1FF); wr(12'h00C, 32'h3);
    ev_acc = '0; trip_lvl[0] = 3'h7; step(3);
    check(flags, 8'h00, "disabled stage flags");
    check(ev_acc, 16'h0000, "disabled stage events");
    trip_lvl[2][2] = 1'b1; step(2);
    check(flags, 8'hC0, "phase and combined trip");
    trip_lvl[2][0] = 1'b1; step(2);
    check(ev_acc, 16'h4400, "trip repeat suppressed");
    ev_acc = '0; trip_lvl = '0; step(2);
    check(flags, 8'hD0, "trip held");
    step(40); check(flags, 8'h00, "trip released");
    check(ev_acc, 16'hA000, "trip off events");
    // latest fault current from hardware and software
    cur_val[3] = 16'h1234; cur_val[5] = 16'h0ABC; cur_req = 8'h28; step(2);
    check(latest_fault_current, 16'h1234, "latest current");
    cur_req = '0;
    rdc(12'h014, 32'h1234, "latest current register");
    wr(12'h014, 32'h0055);
    rdc(12'h014, 32'h0055, "written current");
    cur_val[0] = 16'hFFFF; cur_req = 8'h01; step(3);
    check(latest_fault_current, 16'h0055, "disabled stage current");
    complete_run();
  end
endmodule : test_combined_overcurrent_status

// ---- verilog/combined_overcurrent_status.sv ----
// Purpose: combine overcurrent stage starts and trips into held status flags and events
// Assumes: stage inputs synchronous to core_clk; AHB-Lite single word transfers
// Notes:   zero wait state slave, hrdata registered in the address phase
`timescale 1ns/10ps
`include "ocstat_map.svh"
module combined_overcurrent_status import ocstat_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `OC_TICK_CYCLES  // cycles per second tick
) (
  input  wire logic                                    core_clk,      // system clock
  input  wire logic                                    arst_n,        // async reset
  input  wire logic                                    hsel,          // slave select
  input  wire logic [31:0]                             haddr,         // address
  input  wire logic [1:0]                              htrans,        // transfer type
  input  wire logic                                    hwrite,        // write
  input  wire logic [2:0]                              hsize,         // size
  input  wire logic [31:0]                             hwdata,        // write data
  input  wire logic                                    hready,        // bus ready
  output logic                                         hreadyout,     // slave ready
  output logic                                         hresp,         // always okay
  output logic [31:0]                                  hrdata,        // read data
  input  wire logic [`OC_NUM_STAGES-1:0][2:0]          stage_start,   // per stage phase starts
  input  wire logic [`OC_NUM_STAGES-1:0][2:0]          stage_trip,    // per stage phase trips
  input  wire logic [`OC_NUM_STAGES-1:0]               stage_cur_vld, // fault current strobe
  input  wire logic [`OC_NUM_STAGES-1:0][`OC_CUR_W-1:0] stage_cur,    // recorded fault current
  output flags_t                                       flags,         // held status flags
  output event_t                                       events,        // event pulses
  output logic [`OC_CUR_W-1:0]                         latest_fault_current, // latest fault
  output logic                                         irq            // level interrupt
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ctrl_t                      ctrl_q, ctrl_d;
  logic [`OC_NUM_STAGES-1:0]  stg_en_q, stg_en_d;
  logic [`OC_DLY_W-1:0]       alr_dly_q, alr_dly_d;
  logic [`OC_DLY_W-1:0]       flt_dly_q, flt_dly_d;
  logic [`OC_CUR_W-1:0]       last_i_q, last_i_d;
  logic [`OC_IRQ_W-1:0]       irq_st_q, irq_st_d;
  logic [`OC_IRQ_W-1:0]       irq_en_q, irq_en_d;
  logic                       irq_q, irq_d;
  logic                       wr_pend_q, wr_pend_d;
  logic [11:0]                wr_addr_q, wr_addr_d;
  logic [31:0]                rdata_q, rdata_d;
  logic [27:0]                tick_cnt_q, tick_cnt_d;
  logic                       tick_q, tick_d;
  logic [5:0]                 raw;
  logic [5:0]                 hold;
  logic [`OC_DLY_W-1:0]       cnt_q [6];
  logic [`OC_DLY_W-1:0]       cnt_d [6];
  flags_t                     flags_q, flags_d;
  event_t                     ev_q, ev_d;
  logic [5:0]                 rep_q, rep_d;
  logic                       cur_hit;
  logic [`OC_CUR_W-1:0]       cur_max;
  logic [`OC_IRQ_W-1:0]       irq_set;

  // decode helper for word offsets
  function automatic logic at(input logic [11:0] a, input logic [11:0] off);
    at = (a == off);
  endfunction : at

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // address phase capture, read mux, data phase writes
  always_comb begin
    logic [11:0] ra;
    ra        = haddr[11:0];
    wr_pend_d = hsel && htrans[1] && hready && hwrite;
    wr_addr_d = ra;
    rdata_d   = rdata_q;
    ctrl_d    = ctrl_q;
    stg_en_d  = stg_en_q;
    alr_dly_d = alr_dly_q;
    flt_dly_d = flt_dly_q;
    irq_en_d  = irq_en_q;
    if (hsel && htrans[1] && hready && !hwrite) begin
      if (at(ra, `OC_REG_CTRL)) begin
        rdata_d = 32'(ctrl_q);
      end else if (at(ra, `OC_REG_STG_EN)) begin
        rdata_d = 32'(stg_en_q);
      end else if (at(ra, `OC_REG_ALR_DLY)) begin
        rdata_d = 32'(alr_dly_q);
      end else if (at(ra, `OC_REG_FLT_DLY)) begin
        rdata_d = 32'(flt_dly_q);
      end else if (at(ra, `OC_REG_FLAGS)) begin
        rdata_d = 32'(flags_q);
      end else if (at(ra, `OC_REG_LAST_I)) begin
        rdata_d = 32'(last_i_q);
      end else if (at(ra, `OC_REG_IRQ_ST)) begin
        rdata_d = 32'(irq_st_q);
      end else if (at(ra, `OC_REG_IRQ_EN)) begin
        rdata_d = 32'(irq_en_q);
      end else begin
        rdata_d = 32'h0000_0000;                      // unmapped and write-only read zero
      end
    end
    if (wr_pend_q) begin
      if (at(wr_addr_q, `OC_REG_CTRL)) begin
        ctrl_d = ctrl_t'(hwdata[9:0]);                // see R9 see R10 see R11 see R12
      end else if (at(wr_addr_q, `OC_REG_STG_EN)) begin
        stg_en_d = hwdata[`OC_NUM_STAGES-1:0];
      end else if (at(wr_addr_q, `OC_REG_ALR_DLY)) begin
        alr_dly_d = hwdata[`OC_DLY_W-1:0];            // see R7
      end else if (at(wr_addr_q, `OC_REG_FLT_DLY)) begin
        flt_dly_d = hwdata[`OC_DLY_W-1:0];            // see R8
      end else if (at(wr_addr_q, `OC_REG_IRQ_EN)) begin
        irq_en_d = hwdata[`OC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= ctrl_t'(`OC_CTRL_RST);
      stg_en_q  <= `OC_STG_EN_RST;
      alr_dly_q <= `OC_DLY_RST;
      flt_dly_q <= `OC_DLY_RST;
      irq_en_q  <= '0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
      ctrl_q    <= ctrl_d;
      stg_en_q  <= stg_en_d;
      alr_dly_q <= alr_dly_d;
      flt_dly_q <= flt_dly_d;
      irq_en_q  <= irq_en_d;
    end
  end

  // ---------------------------------------------------------------
  // one-second tick
  // ---------------------------------------------------------------
  // free running divider of the core clock
  always_comb begin
    tick_d     = (tick_cnt_q == 28'(TICK_CYCLES - 1));
    tick_cnt_d = tick_d ? 28'h000_0000 : tick_cnt_q + 28'h000_0001;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 28'h000_0000;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // stage gathering
  // ---------------------------------------------------------------
  // or of enabled stages and largest recorded current this cycle
  always_comb begin
    raw     = 6'h00;
    cur_hit = 1'b0;
    cur_max = '0;
    for (int s = 0; s < `OC_NUM_STAGES; s++) begin
      if (stg_en_q[s]) begin                          // see R1
        raw = raw | {stage_trip[s], stage_start[s]};
        if (stage_cur_vld[s] && (!cur_hit || stage_cur[s] > cur_max)) begin
          cur_hit = 1'b1;
          cur_max = stage_cur[s];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // hold counters, bits 0-2 start phases, 3-5 trip phases
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 6; g++) begin : g_hold
    // reload on activity, count down on tick
    always_comb begin
      if (raw[g]) begin
        cnt_d[g] = (g < 3) ? alr_dly_q : flt_dly_q;  // see R18
      end else if (tick_q && cnt_q[g] != '0) begin
        cnt_d[g] = cnt_q[g] - 16'h0001;               // see R18
      end else begin
        cnt_d[g] = cnt_q[g];
      end
      hold[g] = raw[g] || (cnt_d[g] != '0);           // see R3 see R5
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt_q[g] <= `OC_DLY_RST;
      end else begin
        cnt_q[g] <= cnt_d[g];
      end
    end
  end

  // ---------------------------------------------------------------
  // flags, events, latest current, interrupt
  // ---------------------------------------------------------------
  // rising and falling flags become events under their enables
  always_comb begin
    logic [2:0] srise;
    logic [2:0] sfall;
    logic [2:0] trise;
    logic [2:0] tfall;
    flags_d.phase_start_flag    = hold[2:0];
    flags_d.combined_start_flag = |hold[2:0];       // see R4
    flags_d.phase_trip_flag     = hold[5:3];
    flags_d.combined_trip_flag  = |hold[5:3];       // see R6
    srise = hold[2:0] & ~flags_q.phase_start_flag;
    sfall = ~hold[2:0] & flags_q.phase_start_flag;
    trise = hold[5:3] & ~flags_q.phase_trip_flag;
    tfall = ~hold[5:3] & flags_q.phase_trip_flag;
    // without repeat allow only the first rise of a fault reports
    ev_d.start_on = (ctrl_q.phase_start_on_event_en &&
                     (ctrl_q.start_repeat_allow || !flags_q.combined_start_flag)) ?
                    srise : 3'h0;                     // see R9 see R15
    ev_d.trip_on  = (ctrl_q.phase_trip_on_event_en &&
                     (ctrl_q.trip_repeat_allow || !flags_q.combined_trip_flag)) ?
                    trise : 3'h0;                     // see R12 see R16
    // without repeat allow an off follows only a reported on
    ev_d.start_off = ctrl_q.phase_start_off_event_en ?
                     (sfall & (ctrl_q.start_repeat_allow ? 3'h7 : rep_q[2:0])) : 3'h0; // see R10
    ev_d.trip_off  = ctrl_q.phase_trip_off_event_en ?
                     (tfall & (ctrl_q.trip_repeat_allow ? 3'h7 : rep_q[5:3])) : 3'h0;  // see R13
    ev_d.comb_start_on  = ctrl_q.combined_start_on_event_en &&
                          flags_d.combined_start_flag && !flags_q.combined_start_flag; // see R11
    ev_d.comb_start_off = ctrl_q.combined_start_off_event_en &&
                          !flags_d.combined_start_flag && flags_q.combined_start_flag; // see R11
    ev_d.comb_trip_on   = ctrl_q.combined_trip_on_event_en &&
                          flags_d.combined_trip_flag && !flags_q.combined_trip_flag;   // see R14
    ev_d.comb_trip_off  = ctrl_q.combined_trip_off_event_en &&
                          !flags_d.combined_trip_flag && flags_q.combined_trip_flag;   // see R14
    rep_d = ({ev_d.trip_on, ev_d.start_on} | rep_q) & hold;
    // hardware update wins over a software write in the same cycle
    if (cur_hit) begin
      last_i_d = cur_max;                             // see R2
    end else if (wr_pend_q && at(wr_addr_q, `OC_REG_LAST_I)) begin
      last_i_d = hwdata[`OC_CUR_W-1:0];               // see R2
    end else begin
      last_i_d = last_i_q;
    end
    irq_set = '0;
    irq_set[`OC_IRQ_START_ON]  = flags_d.combined_start_flag && !flags_q.combined_start_flag;
    irq_set[`OC_IRQ_TRIP_ON]   = flags_d.combined_trip_flag && !flags_q.combined_trip_flag;
    irq_set[`OC_IRQ_START_OFF] = !flags_d.combined_start_flag && flags_q.combined_start_flag;
    irq_set[`OC_IRQ_TRIP_OFF]  = !flags_d.combined_trip_flag && flags_q.combined_trip_flag;
    irq_st_d = irq_st_q;
    if (wr_pend_q && at(wr_addr_q, `OC_REG_IRQ_CLR)) begin
      irq_st_d = irq_st_q & ~hwdata[`OC_IRQ_W-1:0];
    end
    irq_st_d = irq_st_d | irq_set;                    // set wins over clear
    irq_d    = |(irq_st_d & irq_en_d);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q  <= '0;
      ev_q     <= '0;
      rep_q    <= 6'h00;
      last_i_q <= '0;
      irq_st_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      flags_q  <= flags_d;
      ev_q     <= ev_d;
      rep_q    <= rep_d;
      last_i_q <= last_i_d;
      irq_st_q <= irq_st_d;
      irq_q    <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hreadyout            = 1'b1 | wr_pend_q & 1'b0;
  assign hresp                = 1'b0;
  assign hrdata               = rdata_q;
  assign flags                = flags_q;
  assign events               = ev_q;
  assign latest_fault_current = last_i_q;
  assign irq                  = irq_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_stage_off;
    @(posedge core_clk) disable iff (!arst_n)
    (!stg_en_q[0] && (stage_trip[7:1] == '0)) |-> (raw[5:3] == 3'h0);
  endproperty
  a_stage_off: assert property (p_stage_off) else $error("disabled stage contributed"); // see R1

  property p_start_set;
    @(posedge core_clk) disable iff (!arst_n)
    (stg_en_q[0] && stage_start[0][0]) |=> flags.phase_start_flag[0];
  endproperty
  a_start_set: assert property (p_start_set) else $error("start flag not set"); // see R3

  property p_comb_start;
    @(posedge core_clk) disable iff (!arst_n)
    flags.combined_start_flag == (|flags.phase_start_flag);
  endproperty
  a_comb_start: assert property (p_comb_start) else $error("combined start mismatch"); // see R4

  property p_trip_set;
    @(posedge core_clk) disable iff (!arst_n)
    (stg_en_q[2] && stage_trip[2][2]) |=> flags.phase_trip_flag[2];
  endproperty
  a_trip_set: assert property (p_trip_set) else $error("trip flag not set"); // see R5

  property p_comb_trip;
    @(posedge core_clk) disable iff (!arst_n)
    flags.combined_trip_flag == (|flags.phase_trip_flag);
  endproperty
  a_comb_trip: assert property (p_comb_trip) else $error("combined trip mismatch"); // see R6

  property p_alr_load;
    @(posedge core_clk) disable iff (!arst_n)
    raw[0] |=> (cnt_q[0] == $past(alr_dly_q));
  endproperty
  a_alr_load: assert property (p_alr_load) else $error("alarm delay not loaded"); // see R7

  property p_flt_load;
    @(posedge core_clk) disable iff (!arst_n)
    raw[5] |=> (cnt_q[5] == $past(flt_dly_q));
  endproperty
  a_flt_load: assert property (p_flt_load) else $error("fault delay not loaded"); // see R8

  property p_count_tick;
    @(posedge core_clk) disable iff (!arst_n)
    (!raw[3] && !tick_q && cnt_q[3] != '0) |=> $stable(cnt_q[3]);
  endproperty
  a_count_tick: assert property (p_count_tick) else $error("count moved off tick"); // see R18

  property p_start_on_en;
    @(posedge core_clk) disable iff (!arst_n)
    (events.start_on != 3'h0) |-> $past(ctrl_q.phase_start_on_event_en);
  endproperty
  a_start_on_en: assert property (p_start_on_en) else $error("start on event while off"); // see R9

  property p_trip_off_en;
    @(posedge core_clk) disable iff (!arst_n)
    (events.trip_off != 3'h0) |-> $past(ctrl_q.phase_trip_off_event_en) && $fell(flags.combined_trip_flag) ||
    $past(ctrl_q.phase_trip_off_event_en);
  endproperty
  a_trip_off_en: assert property (p_trip_off_en) else $error("trip off event while off"); // see R13

  property p_comb_start_ev;
    @(posedge core_clk) disable iff (!arst_n)
    events.comb_start_on |-> $rose(flags.combined_start_flag) && $past(ctrl_q.combined_start_on_event_en);
  endproperty
  a_comb_start_ev: assert property (p_comb_start_ev) else $error("bad combined start event"); // see R11

  property p_repeat;
    @(posedge core_clk) disable iff (!arst_n)
    (events.trip_on != 3'h0) |-> $past(ctrl_q.trip_repeat_allow) || !$past(flags.combined_trip_flag);
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeated trip event not suppressed"); // see R16

endmodule : combined_overcurrent_status

// ---- verilog/ocstat_map.svh ----
// Purpose: register map, field positions and timing counts of the overcurrent status block
// Assumes: 200 MHz core clock, AHB-Lite word registers
// Notes:   definitions only
// Function
// R1: only enabled stages contribute start, trip and fault current
// R2: keep latest fault current, writable by software
// R3: per-phase start flag on while start on, held for alarm clear delay
// R4: combined start flag is OR of the three phase start flags
// R5: per-phase trip flag on while fault on, held for fault clear delay
// R6: combined trip flag is OR of the three phase trip flags
// R7: alarm clear delay 0..65535 s sets start flag hold time
// R8: fault clear delay 0..65535 s sets trip flag hold time
// R9: enable for phase start on events
// R10: enable for phase start off events
// R11: separate enables for combined start on and off events
// R12: enable for phase trip on events
// R13: enable for phase trip off events
// R14: separate enables for combined trip on and off events
// R15: start group repeat setting allows or suppresses repeated events of one fault
// R16: trip group repeat setting allows or suppresses repeated events of one fault
// R17: configurer turns suppression off when consumer needs paired on/off events
// R18: new start or trip reloads countdown; one-second tick counts down to zero
`ifndef OCSTAT_MAP_SVH
`define OCSTAT_MAP_SVH
`define OC_NUM_STAGES  8
`define OC_CUR_W       16
`define OC_DLY_W       16
`define OC_IRQ_W       4
// register byte offsets
`define OC_REG_CTRL    12'h000
`define OC_REG_STG_EN  12'h004
`define OC_REG_ALR_DLY 12'h008
`define OC_REG_FLT_DLY 12'h00C
`define OC_REG_FLAGS   12'h010
`define OC_REG_LAST_I  12'h014
`define OC_REG_IRQ_ST  12'h018
`define OC_REG_IRQ_CLR 12'h01C
`define OC_REG_IRQ_EN  12'h020
// reset values
`define OC_CTRL_RST    10'h000
`define OC_STG_EN_RST  8'hFF
`define OC_DLY_RST     16'h0000
// interrupt status bit positions
`define OC_IRQ_START_ON  0
`define OC_IRQ_TRIP_ON   1
`define OC_IRQ_START_OFF 2
`define OC_IRQ_TRIP_OFF  3
// one-second tick
`define OC_TICK_S      1
`define OC_CLK_HZ      200000000
`define OC_TICK_CYCLES (`OC_TICK_S * `OC_CLK_HZ)
`endif

// ---- verilog/ocstat_pkg.sv ----
// Purpose: types shared by the overcurrent status block
// Assumes: ocstat_map.svh holds the numbers
// Notes:   none
package ocstat_pkg;
  // control register layout, bit 9 downward
  typedef struct packed {
    logic trip_repeat_allow;           // bit 9
    logic start_repeat_allow;          // bit 8
    logic combined_trip_off_event_en;  // bit 7
    logic combined_trip_on_event_en;
    logic phase_trip_off_event_en;
    logic phase_trip_on_event_en;
    logic combined_start_off_event_en;
    logic combined_start_on_event_en;
    logic phase_start_off_event_en;
    logic phase_start_on_event_en;     // bit 0
  } ctrl_t;
  // status flags
  typedef struct packed {
    logic       combined_trip_flag;    // bit 7
    logic [2:0] phase_trip_flag;       // bits 6:4
    logic       combined_start_flag;   // bit 3
    logic [2:0] phase_start_flag;      // bits 2:0
  } flags_t;
  // one-cycle event pulses
  typedef struct packed {
    logic       comb_trip_off;
    logic       comb_trip_on;
    logic [2:0] trip_off;
    logic [2:0] trip_on;
    logic       comb_start_off;
    logic       comb_start_on;
    logic [2:0] start_off;
    logic [2:0] start_on;
  } event_t;
endpackage : ocstat_pkg
